// file: common/smt_pkg.sv
package smt_pkg;

    // Register indices on the switch register port.
    localparam logic [7:0] ADDR_IND_CTRL  = 8'h6e;
    localparam logic [7:0] ADDR_IND_ADDRL = 8'h6f;
    localparam logic [7:0] ADDR_DATA_TOP  = 8'h70;
    localparam logic [7:0] ADDR_DATA_LOW  = 8'h78;
    localparam logic [7:0] ADDR_FDS_A     = 8'h79;
    localparam logic [7:0] ADDR_FDS_B     = 8'h7a;
    localparam logic [7:0] ADDR_FDC_A     = 8'h7b;
    localparam logic [7:0] ADDR_FDC_B     = 8'h7c;
    localparam logic [7:0] ADDR_FAC_A     = 8'h7d;
    localparam logic [7:0] ADDR_FAC_B     = 8'h7e;
    localparam logic [7:0] ADDR_FAS       = 8'h7f;

    // Reset values.
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [68:0] RST_DATA = 69'h0;

    // Indirect control register fields.
    localparam int CTRL_RD_BIT  = 4;
    localparam int CTRL_TSEL_HI = 3;
    localparam int CTRL_TSEL_LO = 2;
    localparam int CTRL_AHI_HI  = 1;
    localparam logic [1:0] TSEL_STATIC = 2'h0;

    // Indirect data word geometry.
    localparam int DATA_W      = 69;
    localparam int DATA_BYTES  = 9;

    // Entry layout common to read and write.
    localparam int F_OVR      = 54;
    localparam int F_VALID    = 53;
    localparam int F_PORT_HI  = 52;
    localparam int F_PORT_LO  = 48;
    localparam int F_MAC_HI   = 47;

    // Read layout.
    localparam int RD_FID_HI  = 60;
    localparam int RD_FID_LO  = 57;
    localparam int RD_USE     = 56;
    localparam int RD_RSVD    = 55;

    // Write layout.
    localparam int WR_FID_HI  = 59;
    localparam int WR_FID_LO  = 56;
    localparam int WR_USE     = 55;

    // Table geometry.
    localparam int ENTRIES    = 8;
    localparam int PORTS      = 5;
    localparam int FID_W      = 4;
    localparam int MAC_W      = 48;

endpackage

// file: logic/smt_static_mac_table.sv
`timescale 1ns/100ps
// Operation
// - A destination lookup searches static and dynamic tables together.
// - A source lookup uses only the dynamic table, never the static one.
// - A destination hit in both tables uses the static result.
// - Entries are reachable only through the external management register port.
// - Static entries never age out; they stay until software changes them.
// - Eight entries, chosen by the indirect address of the command.
// - Readback: group id 60-57, group flag 56, 55 zero, override 54, valid 53.
// - Write data: group id 59-56, group flag 55, override 54, valid 53.
// - The four-bit group id names one of sixteen VLAN groups.
// - Group flag set matches group id plus MAC; clear matches MAC only.
// - Override set forwards despite spanning-tree transmit or receive disable.
// - Entries with valid clear are ignored by lookups.
// - Port bits, bit 0 is port 1; all ones floods all but ingress.
// - The lowest data window register holds data bits 7-0, resets zero.
// - Writing the low indirect address register launches the access.
// - Control bit 4 set selects a read, clear selects a write.
// - Table select 00 directs the access to the static table.
module smt_static_mac_table
(
    // Clock and reset.
    input  wire logic                         clk,
    input  wire logic                         reset_n,
    // Switch register port, fed by the management serial slave.
    input  wire logic [7:0]                   reg_addr,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    input  wire logic [7:0]                   reg_wdata,
    output logic      [7:0]                   reg_rdata,
    // Lookup request.
    input  wire logic                         lkp_req,
    input  wire logic                         lkp_is_da,
    input  wire logic [smt_pkg::MAC_W-1:0]    lkp_mac,
    input  wire logic [smt_pkg::FID_W-1:0]    lkp_fid,
    input  wire logic [smt_pkg::PORTS-1:0]    lkp_ingress,
    // Dynamic table answer for the same request.
    input  wire logic                         dyn_hit,
    input  wire logic [smt_pkg::PORTS-1:0]    dyn_ports,
    // Spanning-tree enables per port.
    input  wire logic [smt_pkg::PORTS-1:0]    stp_tx_en,
    input  wire logic [smt_pkg::PORTS-1:0]    stp_rx_en,
    // Lookup result.
    output logic                              res_valid,
    output logic                              res_hit,
    output logic                              res_static,
    output logic                              res_override,
    output logic      [smt_pkg::PORTS-1:0]    res_ports
);

    localparam int N = smt_pkg::ENTRIES;
    localparam int P = smt_pkg::PORTS;

    logic [7:0]                ctrl_q;
    logic [7:0]                addr_lo_q;
    logic [smt_pkg::DATA_W-1:0] data_q;
    logic [7:0]                fdc_a_q;
    logic [7:0]                fdc_b_q;
    logic [7:0]                fac_a_q;
    logic [7:0]                fac_b_q;
    logic [7:0]                rdata_q;

    // Entry storage, one array per field.
    logic [smt_pkg::FID_W-1:0] ent_fid_q   [N];
    logic                      ent_use_q   [N];
    logic                      ent_ovr_q   [N];
    logic                      ent_valid_q [N];
    logic [P-1:0]              ent_ports_q [N];
    logic [smt_pkg::MAC_W-1:0] ent_mac_q   [N];

    logic                      trig;
    logic                      tbl_hit;
    logic [2:0]                tbl_idx;
    logic [smt_pkg::DATA_W-1:0] rd_word;

    logic                      res_valid_q;
    logic                      res_hit_q;
    logic                      res_static_q;
    logic                      res_ovr_q;
    logic [P-1:0]              res_ports_q;

    // The command fires on the write of the low indirect address byte.
    assign trig = reg_wr && (reg_addr == smt_pkg::ADDR_IND_ADDRL);

    // Only addresses 0..7 with table select 00 reach this table.
    assign tbl_hit = trig
                  && (ctrl_q[smt_pkg::CTRL_TSEL_HI:smt_pkg::CTRL_TSEL_LO]
                      == smt_pkg::TSEL_STATIC)
                  && (ctrl_q[smt_pkg::CTRL_AHI_HI:0] == 2'h0)
                  && (reg_wdata[7:3] == 5'h00);
    assign tbl_idx = reg_wdata[2:0];

    // Readback word in the read layout; bit 55 reads as zero.
    always_comb
    begin
        rd_word = smt_pkg::RST_DATA;
        rd_word[smt_pkg::RD_FID_HI:smt_pkg::RD_FID_LO] = ent_fid_q[tbl_idx];
        rd_word[smt_pkg::RD_USE]   = ent_use_q[tbl_idx];
        rd_word[smt_pkg::RD_RSVD]  = 1'b0;
        rd_word[smt_pkg::F_OVR]    = ent_ovr_q[tbl_idx];
        rd_word[smt_pkg::F_VALID]  = ent_valid_q[tbl_idx];
        rd_word[smt_pkg::F_PORT_HI:smt_pkg::F_PORT_LO] = ent_ports_q[tbl_idx];
        rd_word[smt_pkg::F_MAC_HI:0] = ent_mac_q[tbl_idx];
    end

    // Control and address registers.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_q    <= smt_pkg::RST_BYTE;
            addr_lo_q <= smt_pkg::RST_BYTE;
        end
        else if (reg_wr && reg_addr == smt_pkg::ADDR_IND_CTRL)
        begin
            ctrl_q <= reg_wdata;
        end
        else if (trig)
        begin
            addr_lo_q <= reg_wdata;
        end
    end

    // Data window; a triggered read overwrites it with the entry.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            data_q <= smt_pkg::RST_DATA;
        end
        else if (tbl_hit && ctrl_q[smt_pkg::CTRL_RD_BIT])
        begin
            data_q <= rd_word;
        end
        else if (reg_wr && reg_addr == smt_pkg::ADDR_DATA_TOP)
        begin
            data_q[68:64] <= reg_wdata[4:0];
        end
        else if (reg_wr && reg_addr > smt_pkg::ADDR_DATA_TOP
                 && reg_addr <= smt_pkg::ADDR_DATA_LOW)
        begin
            for (int b = 0; b < smt_pkg::DATA_BYTES - 1; b++)
            begin
                if (reg_addr == smt_pkg::ADDR_DATA_LOW - 8'(b))
                begin
                    data_q[b*8 +: 8] <= reg_wdata;
                end
            end
        end
    end

    // Factory test controls are plain storage with no effect on the table.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fdc_a_q <= smt_pkg::RST_BYTE;
            fdc_b_q <= smt_pkg::RST_BYTE;
            fac_a_q <= smt_pkg::RST_BYTE;
            fac_b_q <= smt_pkg::RST_BYTE;
        end
        else if (reg_wr)
        begin
            if (reg_addr == smt_pkg::ADDR_FDC_A) fdc_a_q <= reg_wdata;
            if (reg_addr == smt_pkg::ADDR_FDC_B) fdc_b_q <= reg_wdata;
            if (reg_addr == smt_pkg::ADDR_FAC_A) fac_a_q <= reg_wdata;
            if (reg_addr == smt_pkg::ADDR_FAC_B) fac_b_q <= reg_wdata;
        end
    end

    // Entries change only on a triggered write; there is no aging path.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < N; i++)
            begin
                ent_fid_q[i]   <= '0;
                ent_use_q[i]   <= 1'b0;
                ent_ovr_q[i]   <= 1'b0;
                ent_valid_q[i] <= 1'b0;
                ent_ports_q[i] <= '0;
                ent_mac_q[i]   <= '0;
            end
        end
        else if (tbl_hit && !ctrl_q[smt_pkg::CTRL_RD_BIT])
        begin
            // Write layout differs from readback by one bit position.
            ent_fid_q[tbl_idx]   <= data_q[smt_pkg::WR_FID_HI:smt_pkg::WR_FID_LO];
            ent_use_q[tbl_idx]   <= data_q[smt_pkg::WR_USE];
            ent_ovr_q[tbl_idx]   <= data_q[smt_pkg::F_OVR];
            ent_valid_q[tbl_idx] <= data_q[smt_pkg::F_VALID];
            ent_ports_q[tbl_idx] <= data_q[smt_pkg::F_PORT_HI:smt_pkg::F_PORT_LO];
            ent_mac_q[tbl_idx]   <= data_q[smt_pkg::F_MAC_HI:0];
        end
    end

    // Register read answer, one cycle after the read strobe.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rdata_q <= smt_pkg::RST_BYTE;
        end
        else if (reg_rd)
        begin
            rdata_q <= smt_pkg::RST_BYTE;
            case (reg_addr)
                smt_pkg::ADDR_IND_CTRL:  rdata_q <= ctrl_q;
                smt_pkg::ADDR_IND_ADDRL: rdata_q <= addr_lo_q;
                smt_pkg::ADDR_DATA_TOP:  rdata_q <= {3'h0, data_q[68:64]};
                smt_pkg::ADDR_FDC_A:     rdata_q <= fdc_a_q;
                smt_pkg::ADDR_FDC_B:     rdata_q <= fdc_b_q;
                smt_pkg::ADDR_FAC_A:     rdata_q <= fac_a_q;
                smt_pkg::ADDR_FAC_B:     rdata_q <= fac_b_q;
                default:
                begin
                    for (int b = 0; b < smt_pkg::DATA_BYTES - 1; b++)
                    begin
                        if (reg_addr == smt_pkg::ADDR_DATA_LOW - 8'(b))
                        begin
                            rdata_q <= data_q[b*8 +: 8];
                        end
                    end
                end
            endcase
        end
    end

    // Match test for one entry.
    function automatic logic ent_match(
        input logic                      valid,
        input logic                      use_grp,
        input logic [smt_pkg::FID_W-1:0] efid,
        input logic [smt_pkg::MAC_W-1:0] emac,
        input logic [smt_pkg::FID_W-1:0] kfid,
        input logic [smt_pkg::MAC_W-1:0] kmac
    );
        // Invalid entries never match; group flag adds the group id to the key.
        ent_match = valid && (emac == kmac) && (!use_grp || efid == kfid);
    endfunction

    logic [N-1:0] hit_vec;

    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_cmp
            assign hit_vec[g] = ent_match(ent_valid_q[g], ent_use_q[g], ent_fid_q[g],
                                          ent_mac_q[g], lkp_fid, lkp_mac);
        end
    endgenerate

    logic         s_hit;
    logic         s_ovr;
    logic [P-1:0] s_ports;
    logic         fin_hit;
    logic         fin_ovr;
    logic [P-1:0] fin_ports;

    // Lowest matching index wins when several entries match.
    always_comb
    begin
        s_hit   = 1'b0;
        s_ovr   = 1'b0;
        s_ports = '0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (hit_vec[i])
            begin
                s_hit   = 1'b1;
                s_ovr   = ent_ovr_q[i];
                s_ports = ent_ports_q[i];
            end
        end
        // Source lookups skip the static table entirely.
        if (!lkp_is_da)
        begin
            s_hit = 1'b0;
        end
        // Static result takes precedence over the dynamic one.
        fin_hit   = s_hit || dyn_hit;
        fin_ovr   = s_hit && s_ovr;
        fin_ports = s_hit ? s_ports : dyn_ports;
        // All ones floods every port except the one the frame came in on.
        if (fin_ports == '1)
        begin
            fin_ports = ~lkp_ingress;
        end
        // Spanning-tree gating applies unless the entry overrides it.
        if (!fin_ovr)
        begin
            fin_ports = fin_ports & stp_tx_en;
            if ((lkp_ingress & stp_rx_en) != lkp_ingress)
            begin
                fin_ports = '0;
            end
        end
    end

    // Result registered so every output leaves a flip-flop.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            res_valid_q  <= 1'b0;
            res_hit_q    <= 1'b0;
            res_static_q <= 1'b0;
            res_ovr_q    <= 1'b0;
            res_ports_q  <= '0;
        end
        else
        begin
            res_valid_q <= lkp_req;
            if (lkp_req)
            begin
                res_hit_q    <= fin_hit;
                res_static_q <= s_hit;
                res_ovr_q    <= fin_ovr;
                res_ports_q  <= fin_ports;
            end
        end
    end

    assign reg_rdata    = rdata_q;
    assign res_valid    = res_valid_q;
    assign res_hit      = res_hit_q;
    assign res_static   = res_static_q;
    assign res_override = res_ovr_q;
    assign res_ports    = res_ports_q;

endmodule

// file: verif/smt_static_mac_table_assertions.sv
`timescale 1ns/100ps
module smt_checker
(
    // Clock and reset.
    input wire logic       clk,
    input wire logic       reset_n,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Lookup.
    input wire logic       lkp_req,
    input wire logic       lkp_is_da,
    input wire logic       dyn_hit,
    input wire logic [4:0] stp_tx_en,
    input wire logic       res_valid,
    input wire logic       res_hit,
    input wire logic       res_static,
    input wire logic       res_override,
    input wire logic [4:0] res_ports
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_answer_next: assert property (lkp_req |=> res_valid)
        else $error("lookup answer missing");
    a_no_spurious: assert property (!lkp_req |=> !res_valid)
        else $error("answer without request");
    a_dyn_kept: assert property (lkp_req && lkp_is_da && dyn_hit |=> res_hit)
        else $error("dynamic hit lost");
    a_source_dyn_only: assert property (lkp_req && !lkp_is_da |=>
        !res_static && res_hit == $past(dyn_hit)) else $error("source lookup used static");
    a_static_is_hit: assert property (res_valid && res_static |-> res_hit)
        else $error("static result without hit");
    a_override_static: assert property (res_valid && res_override |-> res_static)
        else $error("override without static hit");
    a_stp_tx_mask: assert property (res_valid && res_static && !res_override |->
        (res_ports & ~$past(stp_tx_en)) == 5'h00) else $error("disabled port used");
    a_result_holds: assert property (!lkp_req |=>
        $stable({res_hit, res_static, res_override, res_ports})) else $error("result moved");
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
    a_unmapped_zero: assert property (reg_rd && reg_addr < 8'h6e |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    c_static_da: cover property (lkp_req && lkp_is_da ##1 res_static);
    c_override: cover property (res_valid && res_override);
    c_read_data: cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule
bind smt_static_mac_table smt_checker chk (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lkp_req(lkp_req),
    .lkp_is_da(lkp_is_da), .dyn_hit(dyn_hit), .stp_tx_en(stp_tx_en), .res_valid(res_valid),
    .res_hit(res_hit), .res_static(res_static), .res_override(res_override),
    .res_ports(res_ports));

// file: verif/smt_host_model.sv
`timescale 1ns/100ps
module smt_host_model
(
    // Clock.
    input  wire logic       clk,
    // Register port, master side.
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // This master is the only path that touches the table.
    // Factory test indices are skipped outright.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a < 8'h79)
        begin
            @(negedge clk);
            reg_addr = a;
            reg_wdata = d;
            reg_wr = 1'b1;
            @(negedge clk);
            reg_wr = 1'b0;
            // A released bus shows the inverse so stale data never looks valid.
            reg_addr = ~a;
            reg_wdata = ~d;
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        d = 8'h00;
        if (a < 8'h79)
        begin
            @(negedge clk);
            reg_addr = a;
            reg_rd = 1'b1;
            @(negedge clk);
            reg_rd = 1'b0;
            reg_addr = ~a;
            @(negedge clk);
            d = reg_rdata;
        end
    endtask
endmodule

// file: verif/tb.sv
`timescale 1ns/100ps
module tb;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, b;
    logic        reg_wr, reg_rd, res_valid, res_hit, res_static, res_override;
    logic        lkp_req = 1'b0;
    logic        lkp_is_da = 1'b0;
    logic        dyn_hit = 1'b0;
    logic [47:0] lkp_mac = 48'h0;
    logic [3:0]  lkp_fid = 4'h0;
    logic [4:0]  lkp_ingress = 5'h01;
    logic [4:0]  dyn_ports = 5'h10;
    logic [4:0]  stp_tx_en = 5'h1f;
    logic [4:0]  stp_rx_en = 5'h1f;
    logic [4:0]  res_ports;
    int          failures = 0;
    int          n_compared = 0;
    int          cycles = 0;
    localparam logic [47:0] MA = 48'h0a1b2c3d4e5f;
    localparam logic [47:0] MB = 48'hf0e1d2c3b4a5;
    localparam logic [47:0] MC = 48'h123456789abc;
    always #20 clk = ~clk;
    smt_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    smt_static_mac_table uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .lkp_req(lkp_req), .lkp_is_da(lkp_is_da), .lkp_mac(lkp_mac), .lkp_fid(lkp_fid),
        .lkp_ingress(lkp_ingress), .dyn_hit(dyn_hit), .dyn_ports(dyn_ports),
        .stp_tx_en(stp_tx_en), .stp_rx_en(stp_rx_en), .res_valid(res_valid),
        .res_hit(res_hit), .res_static(res_static), .res_override(res_override),
        .res_ports(res_ports));
    task automatic finish_test();
        $display("failures %0d compared %0d", failures, n_compared);
        if (failures == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic miss(input string m);
        $display("mismatch at %0t: %s", $time, m);
        failures++;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles > 10000)
        begin
            miss("run limit reached");
            finish_test();
        end
    end
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
            miss("register byte");
    endtask
    task automatic chk_res(input logic [8:0] exp, input logic [8:0] msk);
        n_compared++;
        if (({res_valid, res_hit, res_static, res_override, res_ports} & msk) !== (exp & msk))
            miss("lookup result");
    endtask
    // Flags are {group flag, override, valid}, packed in the write layout.
    task automatic put(input logic [7:0] k, input logic [3:0] f, input logic [2:0] fl,
                       input logic [4:0] p, input logic [47:0] m, input logic [1:0] ts);
        host.wr(8'h70, 8'h00);
        host.wr(8'h71, {4'h0, f});
        host.wr(8'h72, {fl, p});
        for (int i = 0; i < 6; i++)
            host.wr(8'h73 + 8'(i), m[47 - 8 * i -: 8]);
        host.wr(8'h6e, {4'h0, ts, 2'h0});
        host.wr(8'h6f, k);
    endtask
    task automatic get(input logic [7:0] k, input logic [3:0] f, input logic [2:0] fl,
                       input logic [4:0] p, input logic [47:0] m);
        logic [7:0] d;
        host.wr(8'h6e, 8'h10);
        host.wr(8'h6f, k);
        host.rd(8'h71, d);
        chk_byte(d, {3'h0, f, fl[2]});
        host.rd(8'h72, d);
        chk_byte(d, {1'b0, fl[1:0], p});
        for (int i = 0; i < 6; i++)
        begin
            host.rd(8'h73 + 8'(i), d);
            chk_byte(d, m[47 - 8 * i -: 8]);
        end
    endtask
    // Expected result is {valid, hit, static, override, ports}.
    task automatic lk(input logic da, input logic [47:0] m, input logic [3:0] f,
                      input logic dh, input logic [4:0] stx, input logic [8:0] exp,
                      input logic [8:0] msk);
        @(negedge clk);
        lkp_req = 1'b1;
        lkp_is_da = da;
        lkp_mac = m;
        lkp_fid = f;
        lkp_ingress = (m == MB) ? 5'h02 : 5'h01;
        dyn_hit = dh;
        stp_tx_en = stx;
        @(negedge clk);
        lkp_req = 1'b0;
        chk_res(exp, msk);
    endtask
    initial
    begin
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        host.rd(8'h78, b);
        chk_byte(b, 8'h00);
        host.wr(8'h10, 8'h5a);
        host.rd(8'h10, b);
        chk_byte(b, 8'h00);
        host.wr(8'h78, 8'ha5);
        host.rd(8'h78, b);
        chk_byte(b, 8'ha5);
        put(8'h00, 4'h0, 3'h1, 5'h06, MA, 2'h0);
        put(8'h07, 4'h5, 3'h7, 5'h1f, MB, 2'h0);
        put(8'h03, 4'h0, 3'h0, 5'h01, MC, 2'h0);
        put(8'h08, 4'h0, 3'h1, 5'h01, MC, 2'h0);
        get(8'h00, 4'h0, 3'h1, 5'h06, MA);
        get(8'h07, 4'h5, 3'h7, 5'h1f, MB);
        lk(1'b1, MA, 4'h0, 1'b1, 5'h1f, 9'h1c6, 9'h1ff);
        lk(1'b0, MA, 4'h0, 1'b0, 5'h1f, 9'h110, 9'h1ff);
        lk(1'b1, MB, 4'h5, 1'b0, 5'h00, 9'h1fd, 9'h1ff);
        lk(1'b1, MB, 4'h4, 1'b0, 5'h1f, 9'h100, 9'h1e0);
        lk(1'b1, MC, 4'h0, 1'b0, 5'h1f, 9'h100, 9'h1e0);
        lk(1'b1, MA, 4'h0, 1'b0, 5'h1b, 9'h1c2, 9'h1ff);
        stp_rx_en = 5'h1e;
        lk(1'b1, MA, 4'h0, 1'b0, 5'h1f, 9'h1c0, 9'h1ff);
        stp_rx_en = 5'h1f;
        put(8'h00, 4'h0, 3'h0, 5'h00, MA, 2'h1);
        repeat (2000) @(negedge clk);
        lk(1'b1, MA, 4'h0, 1'b0, 5'h1f, 9'h1c6, 9'h1ff);
        put(8'h00, 4'h0, 3'h0, 5'h00, MA, 2'h0);
        lk(1'b1, MA, 4'h0, 1'b1, 5'h1f, 9'h190, 9'h1ff);
        finish_test();
    end
endmodule
